/* File: common/eilr_pkg.sv */
// constants for the extended identification leaf responder
// assumes a 40 MHz core clock and strap pins that only
// change while the core is held in reset

package eilr_pkg;

	// leaf numbers served by the block
	localparam logic [31:0] LEAF_PM    = 32'h8000_0007;
	localparam logic [31:0] LEAF_ADDR  = 32'h8000_0008;
	localparam logic [31:0] LEAF_RSV9  = 32'h8000_0009;
	localparam logic [31:0] LEAF_VIRT  = 32'h8000_000A;
	localparam logic [31:0] LEAF_TLB1G = 32'h8000_0019;
	localparam logic [31:0] LEAF_PERF  = 32'h8000_001A;

	// power management flag positions, fourth word
	localparam int PM_STAMP_RATE_BIT  = 8;
	localparam int PM_HW_PERF_BIT     = 7;
	localparam int PM_HUNDRED_MHZ_BIT = 6;
	localparam int PM_SW_THERMAL_BIT  = 5;
	localparam int PM_HW_THERMAL_BIT  = 4;
	localparam int PM_TRIP_BIT        = 3;
	localparam int PM_VOLT_CODE_BIT   = 2;
	localparam int PM_FREQ_CODE_BIT   = 1;
	localparam int PM_TEMP_SENSOR_BIT = 0;

	// address size leaf values
	localparam logic [7:0] LIN_ADDR_LONG  = 8'h30;
	localparam logic [7:0] LIN_ADDR_SHORT = 8'h20;
	localparam logic [7:0] PHYS_ADDR_BITS = 8'h30;
	localparam logic [3:0] CORE_SEL_BITS  = 4'h2;
	localparam int         NUM_CORES      = 4;

	// virtualization leaf values
	localparam logic [31:0] VIRT_ASID_COUNT = 32'h0000_0040;
	localparam int VIRT_NEXT_IP_BIT = 3;
	localparam int VIRT_LOCK_BIT    = 2;
	localparam int VIRT_BRANCH_BIT  = 1;
	localparam int VIRT_NESTED_BIT  = 0;

	// tlb associativity codes and 1 GB entry count
	localparam logic [3:0]  ASSOC_OFF      = 4'h0;
	localparam logic [3:0]  ASSOC_FULL     = 4'hF;
	localparam logic [11:0] L1D_1G_ENTRIES = 12'h030;
	localparam logic [11:0] NO_ENTRIES     = 12'h000;

	// register port byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_PM_FLAGS = 8'h08;
	localparam logic [7:0] OFS_ADDR     = 8'h0C;
	localparam logic [7:0] OFS_CORES    = 8'h10;
	localparam logic [7:0] OFS_VIRT_REV = 8'h14;
	localparam logic [7:0] OFS_VIRT_ID  = 8'h18;
	localparam logic [7:0] OFS_VIRT_FL  = 8'h1C;
	localparam logic [7:0] OFS_TLB_L1   = 8'h20;
	localparam logic [7:0] OFS_TLB_L2   = 8'h24;
	localparam logic [7:0] OFS_PERF     = 8'h28;

	// reset value of the thermal advertise mask
	localparam logic [1:0] CTRL_RST = 2'h3;

	// strap settle count after reset release
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// strap capture phase
	typedef enum logic {
		PH_SETTLE = 1'b0,
		PH_READY  = 1'b1
	} eilr_phase_t;

endpackage

/* File: hdl/eilr_responder.sv */
// extended identification leaf responder
// assumes leaf requests and register strobes come from
// logic on clk_i; strap pins are asynchronous and stable
//
// Summary of operation
// RL1: power leaf bit 8 stamp rate constant
// RL2: power leaf bit 7 hardware perf states
// RL3: power leaf bit 6 hundred megahertz steps
// RL4: power leaf bit 3 thermal trip supported
// RL5: power leaf bits 2:1 read zero
// RL6: power leaf bits 5:4 from product straps
// RL7: linear width 30h with long mode, else 20h
// RL8: physical address width always 30h
// RL9: core select bit count is 2h
// RL10: enabled core count minus one reported
// RL11: virtualization revision in low byte
// RL12: address space id count is 40h
// RL13: virt flags: 0, then three ones
// RL14: 1 GB data tlb: full, 48 entries
// RL15: other 1 GB tlb fields read zero
// RL16: virt leaf reserved without virt feature
// RL17: associativity 0h absent, Fh full
// RL18: reserved bits and leaves read zero
// RL19: answer depends on leaf and latched straps
//
// The register offsets and the address-and-strobe port were decided locally.

`timescale 1ns/1ps

module eilr_responder #(
	parameter logic [7:0] VIRT_REV     = 8'h0A, // arbitrary value
	parameter logic       UNALIGNED_MV = 1'b0,
	parameter logic       WIDE_FLOAT   = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        leaf_req_i,
	input  wire logic [31:0] leaf_i,
	output logic             res_valid_o,
	output logic      [31:0] res_w0_o,
	output logic      [31:0] res_w1_o,
	output logic      [31:0] res_w2_o,
	output logic      [31:0] res_w3_o,
	input  wire logic  [7:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic        long_mode_i,
	input  wire logic        virt_present_i,
	input  wire logic        sw_thermal_i,
	input  wire logic        hw_thermal_i,
	input  wire logic  [3:0] core_disable_i,
	output logic             straps_ready_o
);

	// all block state except the reset release chain in one record
	typedef struct packed {
		logic  [7:0]          s1;      // strap sync, first
		logic  [7:0]          s2;      // strap sync, second
		logic  [1:0]          settle;  // settle counter
		eilr_pkg::eilr_phase_t phase;  // capture phase
		logic                 lmode;   // latched long mode
		logic                 virt;    // latched virt flag
		logic                 sw_th;   // latched sw thermal
		logic                 hw_th;   // latched hw thermal
		logic  [7:0]          nc;      // cores minus one
		logic  [1:0]          th_mask; // software mask
		logic                 valid;   // answer strobe
		logic [127:0]         res;     // four answer words
		logic [31:0]          rdata;   // register read data
	} eilr_state_t;

	eilr_state_t q;     // registered state
	eilr_state_t n;     // next state
	logic  [1:0] rst_q; // reset release chain
	logic        rst_n; // synchronous reset copy
	logic  [1:0] th_adv; // thermal bits advertised
	logic [127:0] rd_words; // words behind register reads

	// reset: asserts at once, releases after two edges
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end

	assign rst_n = rst_q[1];

	// enabled cores minus one; core zero never drops out
	// so the field cannot wrap below zero
	function automatic logic [7:0] cores_m1(
		input logic [3:0] dis
	);
		logic [7:0] cnt;
		cnt = 8'h00;
		for (int i = 1; i < eilr_pkg::NUM_CORES; i++) begin
			if (!dis[i]) begin
				cnt = cnt + 8'h01; // [RL10]
			end
		end
		return cnt;
	endfunction

	// four result words for one leaf, word 0 lowest
	function automatic logic [127:0] leaf_words(
		input logic [31:0] leaf,
		input logic        lmode,
		input logic        virt,
		input logic  [1:0] th,
		input logic  [7:0] nc
	);
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		logic [31:0] w3;
		w0 = 32'h0000_0000; // [RL18]
		w1 = 32'h0000_0000;
		w2 = 32'h0000_0000;
		w3 = 32'h0000_0000;
		if (leaf == eilr_pkg::LEAF_PM) begin
			// fixed power flags
			w3[eilr_pkg::PM_STAMP_RATE_BIT]  = 1'b1; // [RL1]
			w3[eilr_pkg::PM_HW_PERF_BIT]     = 1'b1; // [RL2]
			w3[eilr_pkg::PM_HUNDRED_MHZ_BIT] = 1'b1; // [RL3]
			w3[eilr_pkg::PM_TRIP_BIT]        = 1'b1; // [RL4]
			w3[eilr_pkg::PM_VOLT_CODE_BIT]   = 1'b0; // [RL5]
			w3[eilr_pkg::PM_FREQ_CODE_BIT]   = 1'b0; // [RL5]
			w3[eilr_pkg::PM_TEMP_SENSOR_BIT] = 1'b1;
			// product dependent thermal flags
			w3[eilr_pkg::PM_SW_THERMAL_BIT]  = th[0]; // [RL6]
			w3[eilr_pkg::PM_HW_THERMAL_BIT]  = th[1]; // [RL6]
		end else if (leaf == eilr_pkg::LEAF_ADDR) begin
			// linear width follows long mode
			w0[15:8] = lmode ? eilr_pkg::LIN_ADDR_LONG
				: eilr_pkg::LIN_ADDR_SHORT; // [RL7]
			w0[7:0] = eilr_pkg::PHYS_ADDR_BITS; // [RL8]
			w2[15:12] = eilr_pkg::CORE_SEL_BITS; // [RL9]
			w2[7:0] = nc; // [RL10]
		end else if (leaf == eilr_pkg::LEAF_VIRT) begin
			// whole leaf zero when virt is absent
			if (virt) begin // [RL16]
				w0[7:0] = VIRT_REV; // [RL11]
				w1 = eilr_pkg::VIRT_ASID_COUNT; // [RL12]
				w3[eilr_pkg::VIRT_NEXT_IP_BIT] = 1'b0; // [RL13]
				w3[eilr_pkg::VIRT_LOCK_BIT] = 1'b1; // [RL13]
				w3[eilr_pkg::VIRT_BRANCH_BIT] = 1'b1; // [RL13]
				w3[eilr_pkg::VIRT_NESTED_BIT] = 1'b1; // [RL13]
			end
		end else if (leaf == eilr_pkg::LEAF_TLB1G) begin
			// only the first-level data tlb holds 1 GB pages
			w0[31:28] = eilr_pkg::ASSOC_FULL; // [RL14] [RL17]
			w0[27:16] = eilr_pkg::L1D_1G_ENTRIES; // [RL14]
			w0[15:12] = eilr_pkg::ASSOC_OFF; // [RL15] [RL17]
			w0[11:0] = eilr_pkg::NO_ENTRIES; // [RL15]
			w1[31:28] = eilr_pkg::ASSOC_OFF; // [RL15] [RL17]
			w1[27:16] = eilr_pkg::NO_ENTRIES; // [RL15]
			w1[15:12] = eilr_pkg::ASSOC_OFF; // [RL15] [RL17]
			w1[11:0] = eilr_pkg::NO_ENTRIES; // [RL15]
		end else if (leaf == eilr_pkg::LEAF_PERF) begin
			// tuning hints, set per product
			w0[1] = UNALIGNED_MV;
			w0[0] = WIDE_FLOAT;
		end
		return {w3, w2, w1, w0};
	endfunction

	// thermal flags pass only where software allows
	assign th_adv = {q.hw_th & q.th_mask[1],
		q.sw_th & q.th_mask[0]}; // [RL6]

	// register reads see the same tables as the core
	always_comb begin
		if (reg_addr_i == eilr_pkg::OFS_PM_FLAGS) begin
			rd_words = leaf_words(eilr_pkg::LEAF_PM,
				q.lmode, q.virt, th_adv, q.nc);
		end else if (reg_addr_i == eilr_pkg::OFS_ADDR ||
			reg_addr_i == eilr_pkg::OFS_CORES) begin
			rd_words = leaf_words(eilr_pkg::LEAF_ADDR,
				q.lmode, q.virt, th_adv, q.nc);
		end else if (reg_addr_i == eilr_pkg::OFS_TLB_L1 ||
			reg_addr_i == eilr_pkg::OFS_TLB_L2) begin
			rd_words = leaf_words(eilr_pkg::LEAF_TLB1G,
				q.lmode, q.virt, th_adv, q.nc);
		end else if (reg_addr_i == eilr_pkg::OFS_PERF) begin
			rd_words = leaf_words(eilr_pkg::LEAF_PERF,
				q.lmode, q.virt, th_adv, q.nc);
		end else begin
			// virt offsets, or nothing useful
			rd_words = leaf_words(eilr_pkg::LEAF_VIRT,
				q.lmode, q.virt, th_adv, q.nc);
		end
	end

	// next state
	always_comb begin
		n = q;
		// two-stage strap synchroniser
		n.s1 = {long_mode_i, virt_present_i, sw_thermal_i,
			hw_thermal_i, core_disable_i};
		n.s2 = q.s1;
		n.valid = 1'b0;
		n.rdata = 32'h0000_0000;

		// straps caught once, then frozen until reset,
		// so only writes to the thermal mask shift answers under running software
		case (q.phase)
			eilr_pkg::PH_SETTLE: begin
				if (q.settle == eilr_pkg::STRAP_SETTLE) begin
					n.phase = eilr_pkg::PH_READY;
					n.lmode = q.s2[7]; // [RL19]
					n.virt = q.s2[6];
					n.sw_th = q.s2[5];
					n.hw_th = q.s2[4];
					n.nc = cores_m1(q.s2[3:0]); // [RL10]
				end else begin
					n.settle = q.settle + 2'h1;
				end
			end
			eilr_pkg::PH_READY: begin
				n.phase = eilr_pkg::PH_READY;
			end
			default: begin
				n.phase = eilr_pkg::PH_SETTLE;
			end
		endcase

		// answer a leaf request one cycle later
		if (leaf_req_i) begin
			n.valid = 1'b1;
			n.res = leaf_words(leaf_i, q.lmode, q.virt,
				th_adv, q.nc); // [RL19]
		end

		// register writes; only the mask is writable
		if (reg_we_i && reg_addr_i == eilr_pkg::OFS_CTRL) begin
			n.th_mask = reg_wdata_i[1:0];
		end

		// register reads; unmapped offsets read zero
		if (reg_re_i) begin
			if (reg_addr_i == eilr_pkg::OFS_CTRL) begin
				n.rdata = {30'h0000_0000, q.th_mask};
			end else if (reg_addr_i == eilr_pkg::OFS_STATUS) begin
				n.rdata = {16'h0000, q.nc, 3'h0,
					q.phase == eilr_pkg::PH_READY,
					q.lmode, q.virt, q.sw_th, q.hw_th};
			end else if (reg_addr_i == eilr_pkg::OFS_PM_FLAGS) begin
				n.rdata = rd_words[127:96];
			end else if (reg_addr_i == eilr_pkg::OFS_ADDR) begin
				n.rdata = rd_words[31:0];
			end else if (reg_addr_i == eilr_pkg::OFS_CORES) begin
				n.rdata = rd_words[95:64];
			end else if (reg_addr_i == eilr_pkg::OFS_VIRT_REV) begin
				n.rdata = rd_words[31:0]; // [RL16]
			end else if (reg_addr_i == eilr_pkg::OFS_VIRT_ID) begin
				n.rdata = rd_words[63:32];
			end else if (reg_addr_i == eilr_pkg::OFS_VIRT_FL) begin
				n.rdata = rd_words[127:96];
			end else if (reg_addr_i == eilr_pkg::OFS_TLB_L1) begin
				n.rdata = rd_words[31:0];
			end else if (reg_addr_i == eilr_pkg::OFS_TLB_L2) begin
				n.rdata = rd_words[63:32];
			end else if (reg_addr_i == eilr_pkg::OFS_PERF) begin
				n.rdata = rd_words[31:0];
			end else begin
				n.rdata = 32'h0000_0000; // [RL18]
			end
		end
	end

	// state register; reset values are constants only
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.th_mask <= eilr_pkg::CTRL_RST;
		end else begin
			q <= n;
		end
	end

	// outputs straight from flip-flops
	assign res_valid_o    = q.valid;
	assign res_w0_o       = q.res[31:0];
	assign res_w1_o       = q.res[63:32];
	assign res_w2_o       = q.res[95:64];
	assign res_w3_o       = q.res[127:96];
	assign reg_rdata_o    = q.rdata;
	assign straps_ready_o = q.phase == eilr_pkg::PH_READY;

	// checks on the answers and the latched straps
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	logic [127:0] res_all; // all answer words
	assign res_all = q.res;

	// request patterns
	sequence s_pm_req;
		leaf_req_i && leaf_i == eilr_pkg::LEAF_PM;
	endsequence

	sequence s_addr_req;
		leaf_req_i && leaf_i == eilr_pkg::LEAF_ADDR;
	endsequence

	sequence s_virt_req;
		leaf_req_i && leaf_i == eilr_pkg::LEAF_VIRT;
	endsequence

	sequence s_tlb_req;
		leaf_req_i && leaf_i == eilr_pkg::LEAF_TLB1G;
	endsequence

	// a settled request, then the same leaf again
	sequence s_repeat;
		(leaf_req_i && straps_ready_o && !reg_we_i)
		##1 (leaf_req_i && $stable(leaf_i));
	endsequence

	AST_PM_ONES: assert property ( // [RL1] [RL2] [RL3] [RL4]
		s_pm_req |=> res_valid_o && res_w3_o[8:6] == 3'h7
			&& res_w3_o[3])
		else $error("power leaf fixed ones wrong");

	AST_PM_ZEROS: assert property ( // [RL5]
		s_pm_req |=> res_w3_o[2:1] == 2'h0
			&& res_w3_o[31:9] == 23'h00_0000)
		else $error("power leaf zero bits set");

	AST_PM_THERMAL: assert property ( // [RL6]
		s_pm_req |=> res_w3_o[5:4] == {$past(q.sw_th & q.th_mask[0]),
			$past(q.hw_th & q.th_mask[1])})
		else $error("thermal flags not from straps");

	AST_ADDR_WIDTH: assert property ( // [RL7] [RL8]
		s_addr_req |=> res_w0_o[7:0] == eilr_pkg::PHYS_ADDR_BITS
			&& res_w0_o[15:8] == ($past(q.lmode)
			? eilr_pkg::LIN_ADDR_LONG : eilr_pkg::LIN_ADDR_SHORT))
		else $error("address widths wrong");

	AST_ADDR_CORES: assert property ( // [RL9] [RL10]
		s_addr_req |=> res_w2_o[15:12] == eilr_pkg::CORE_SEL_BITS
			&& res_w2_o[7:0] == $past(q.nc))
		else $error("core count word wrong");

	AST_VIRT_ON: assert property ( // [RL11] [RL12] [RL13]
		s_virt_req ##0 q.virt |=> res_w0_o == {24'h00_0000, VIRT_REV}
			&& res_w1_o == eilr_pkg::VIRT_ASID_COUNT
			&& res_w3_o == 32'h0000_0007)
		else $error("virt leaf words wrong");

	AST_VIRT_OFF: assert property ( // [RL16]
		s_virt_req ##0 !q.virt |=> res_all == 128'h0)
		else $error("virt leaf not reserved");

	AST_TLB: assert property ( // [RL14] [RL15] [RL17]
		s_tlb_req |=> res_w0_o == 32'hF030_0000
			&& res_w1_o == 32'h0000_0000)
		else $error("1 GB tlb words wrong");

	AST_RSV: assert property ( // [RL18]
		leaf_req_i && leaf_i == eilr_pkg::LEAF_RSV9
			|=> res_valid_o && res_all == 128'h0)
		else $error("reserved leaf not zero");

	AST_REPEAT: assert property ( // [RL19]
		s_repeat |=> $stable(res_all))
		else $error("repeated leaf gave new answer");

	AST_FROZEN: assert property ( // [RL19]
		straps_ready_o |=> straps_ready_o && $stable(q.nc)
			&& $stable(q.lmode) && $stable(q.virt))
		else $error("latched straps moved");

endmodule

/* File: tb/eilr_leaf_requester.sv */
// model of the core step that asks the responder for leaves
// assumes answers come as a one-cycle strobe after the taking edge
`timescale 1ns/1ps

module eilr_leaf_requester (
	input  wire logic        clk_i,
	output logic             req_o,
	output logic      [31:0] leaf_o,
	input  wire logic        valid_i,
	input  wire logic [31:0] w0_i,
	input  wire logic [31:0] w1_i,
	input  wire logic [31:0] w2_i,
	input  wire logic [31:0] w3_i
);
	// quiet request lines until the first ask
	initial begin
		req_o  = 1'b0;
		leaf_o = 32'h0000_0000;
	end

	// one request; words return as {w3, w2, w1, w0}
	task automatic ask(input logic [31:0] leaf, output logic [127:0] words, output logic seen);
		int n;
		@(posedge clk_i);
		req_o  <= 1'b1;
		leaf_o <= leaf;
		@(posedge clk_i);
		req_o  <= 1'b0;
		// leaf lines are meaningless once taken: show the inverse, never a stale copy
		leaf_o <= ~leaf;
		#1;
		n = 0;
		// bounded wait so a silent responder cannot hang us
		while (valid_i !== 1'b1 && n < 4) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		seen  = (valid_i === 1'b1);
		words = {w3_i, w2_i, w1_i, w0_i};
		// strobe must be gone one cycle later
		@(posedge clk_i);
		#1;
		if (valid_i !== 1'b0) begin
			seen = 1'b0;
		end
	endtask

	// one leaf asked on two edges in a row; both answers returned
	task automatic ask_pair(input logic [31:0] leaf, output logic [127:0] first,
		output logic [127:0] second);
		@(posedge clk_i);
		req_o  <= 1'b1;
		leaf_o <= leaf;
		@(posedge clk_i);
		#1;
		first = {w3_i, w2_i, w1_i, w0_i};
		@(posedge clk_i);
		req_o  <= 1'b0;
		leaf_o <= ~leaf;
		#1;
		second = {w3_i, w2_i, w1_i, w0_i};
	endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the identification leaf responder
// assumes straps move only while reset is held
`timescale 1ns/1ps

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end

module testbench;
	localparam int LIMIT = 5000; // runs need well under a thousand cycles
	localparam logic [7:0] VREV = 8'h5C; // arbitrary revision value

	logic        clk, rst_n, leaf_req, res_valid, reg_we, reg_re, ready;
	logic        long_mode, virt_on, sw_th, hw_th;
	logic [31:0] leaf, w0, w1, w2, w3, wdata, rdata, pm;
	logic  [7:0] reg_addr, cores_m1;
	logic  [3:0] core_dis;
	logic [127:0] addr_exp, w_a, w_b; // address leaf expectation and pair answers
	int          errors, comparisons, cycles;
	// strap sets: {long mode, virt, sw thermal, hw thermal, core disables}
	logic  [7:0] cfg_tab [3] = '{8'hE0, 8'h1A, 8'hFF};

	// 40 MHz clock
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	eilr_responder #(.VIRT_REV(VREV), .UNALIGNED_MV(1'b1), .WIDE_FLOAT(1'b0)) u_eilr_responder (
		.clk_i(clk), .reset_n_i(rst_n), .leaf_req_i(leaf_req), .leaf_i(leaf),
		.res_valid_o(res_valid), .res_w0_o(w0), .res_w1_o(w1), .res_w2_o(w2), .res_w3_o(w3),
		.reg_addr_i(reg_addr), .reg_wdata_i(wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
		.reg_rdata_o(rdata), .long_mode_i(long_mode), .virt_present_i(virt_on),
		.sw_thermal_i(sw_th), .hw_thermal_i(hw_th), .core_disable_i(core_dis),
		.straps_ready_o(ready));

	eilr_leaf_requester u_eilr_leaf_requester (
		.clk_i(clk), .req_o(leaf_req), .leaf_o(leaf), .valid_i(res_valid),
		.w0_i(w0), .w1_i(w1), .w2_i(w2), .w3_i(w3));

	// verdict and end of run, shared by the main flow and the timeout
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("ERROR timeout expected finish seen hang");
			finish_test();
		end
	end

	// one-cycle read, data taken in the following cycle only
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// one-cycle write
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we   <= 1'b1;
		reg_addr <= a;
		wdata    <= d;
		@(posedge clk);
		reg_we   <= 1'b0;
	endtask

	task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		reg_rd(a, d);
		`CHK(what, exp, d)
	endtask

	task automatic check_leaf(input string what, input logic [31:0] lf, input logic [127:0] exp);
		logic [127:0] w;
		logic         seen;
		u_eilr_leaf_requester.ask(lf, w, seen);
		`CHK({what, " strobe"}, 1'b1, seen)
		`CHK(what, exp, w)
	endtask

	// main sequence: one pass per strap set, each behind its own reset
	initial begin
		int n;
		{rst_n, reg_we, reg_re, long_mode, virt_on, sw_th, hw_th} = '0;
		{wdata, reg_addr, core_dis} = '0;
		for (int c = 0; c < 3; c++) begin
			@(posedge clk);
			rst_n <= 1'b0;
			{long_mode, virt_on, sw_th, hw_th, core_dis} <= cfg_tab[c];
			repeat (2) @(posedge clk);
			rst_n <= 1'b1;
			n = 0;
			while (ready !== 1'b1 && n < 20) begin
				@(posedge clk);
				#1;
				n++;
			end
			`CHK("straps ready", 1'b1, ready) // straps latched
			// enabled cores minus one; core 0 cannot be disabled
			cores_m1 = {7'h0, ~core_dis[1]} + {7'h0, ~core_dis[2]} + {7'h0, ~core_dis[3]};
			pm = {23'h0, 3'h7, sw_th, hw_th, 4'h9};
			addr_exp = {32'h0, 16'h0, 4'h2, 4'h0, cores_m1, 32'h0,
				16'h0, (long_mode ? 8'h30 : 8'h20), 8'h30};
			// asked twice: answers must repeat exactly
			for (int r = 0; r < 2; r++) begin
				check_leaf("power", eilr_pkg::LEAF_PM, {pm, 96'h0}); // flags
				check_leaf("addr", eilr_pkg::LEAF_ADDR, addr_exp); // sizes
				check_leaf("virt", eilr_pkg::LEAF_VIRT, virt_on ? {32'h0000_0007, 32'h0, 32'h0000_0040,
					24'h0, VREV} : 128'h0); // virt words
				check_leaf("tlb", eilr_pkg::LEAF_TLB1G, {96'h0, 32'hF030_0000}); // tlb
				check_leaf("perf", eilr_pkg::LEAF_PERF, {96'h0, 32'h0000_0002}); // tuning hints: unaligned move bit set
				check_leaf("rsv9", eilr_pkg::LEAF_RSV9, 128'h0); // reserved leaf
				check_leaf("unused", 32'h8000_0006, 128'h0); // outside the set
			end
			// same leaf on two edges in a row: both answers exact
			u_eilr_leaf_requester.ask_pair(eilr_pkg::LEAF_ADDR, w_a, w_b);
			`CHK("pair first", addr_exp, w_a) // back to back
			`CHK("pair second", addr_exp, w_b) // repeat identical
			check_reg("ctrl", eilr_pkg::OFS_CTRL, 32'h0000_0003); // mask starts open
			check_reg("status", eilr_pkg::OFS_STATUS, {16'h0, cores_m1, 4'h1,
				long_mode, virt_on, sw_th, hw_th}); // latched straps
			check_reg("pm reg", eilr_pkg::OFS_PM_FLAGS, pm); // same flags
			check_reg("cores reg", eilr_pkg::OFS_CORES, {16'h0, 8'h20, cores_m1}); // count
			check_reg("asid reg", eilr_pkg::OFS_VIRT_ID, virt_on ? 32'h0000_0040 : 32'h0);
			check_reg("tlb reg", eilr_pkg::OFS_TLB_L2, 32'h0); // second level empty
			check_reg("unmapped", 8'h2C, 32'h0); // nothing mapped
			// read-only place keeps its value
			reg_wr(eilr_pkg::OFS_PM_FLAGS, 32'h0000_0000); // write ignored
			check_reg("pm ro", eilr_pkg::OFS_PM_FLAGS, pm); // unchanged
			// mask bit 0 keeps software thermal, hardware thermal hidden
			reg_wr(eilr_pkg::OFS_CTRL, 32'h0000_0001); // hide hardware thermal
			check_leaf("power masked", eilr_pkg::LEAF_PM, {pm & 32'hFFFF_FFEF, 96'h0});
			$display("test strap set %0d done", c);
		end
		finish_test();
	end
endmodule
